// >>> core/wdc_pkg.sv
// -----------------------------------------------------------------------------
// Shared constants for the watchdog configuration port.
// -----------------------------------------------------------------------------
package wdc_pkg;

	// -------------------------------------------------------------------------
	// Host I/O port map.
	// -------------------------------------------------------------------------
	localparam logic [15:0] WDC_INDEX_PORT = 16'h002e; // Index (and unlock) port.
	localparam logic [15:0] WDC_DATA_PORT  = 16'h002f; // Data port, one above the index port.

	// -------------------------------------------------------------------------
	// Key bytes written to the index port.
	// -------------------------------------------------------------------------
	localparam logic [7:0] WDC_UNLOCK_BYTE = 8'h87; // Written twice to enter configuration mode.
	localparam logic [7:0] WDC_LOCK_BYTE   = 8'haa; // Written once to leave configuration mode.

	// -------------------------------------------------------------------------
	// Register indices and bank selection.
	// -------------------------------------------------------------------------
	localparam logic [7:0] WDC_IDX_LDN      = 8'h07; // Logical device select register.
	localparam logic [7:0] WDC_IDX_UNIT     = 8'hf5; // Watchdog unit control register.
	localparam logic [7:0] WDC_IDX_COUNT    = 8'hf6; // Watchdog timeout count register.
	localparam logic [7:0] WDC_LDN_WATCHDOG = 8'h08; // Logical device number of the watchdog bank.
	localparam int         WDC_UNIT_BIT     = 3;     // Set selects minutes, clear selects seconds.

	// -------------------------------------------------------------------------
	// Reset values.
	// -------------------------------------------------------------------------
	localparam logic [7:0] WDC_RST_LDN   = 8'h00; // Logical device select after reset.
	localparam logic [7:0] WDC_RST_UNIT  = 8'h00; // Seconds, after reset.
	localparam logic [7:0] WDC_RST_COUNT = 8'h00; // Countdown stopped after reset.
	localparam logic [7:0] WDC_RST_INDEX = 8'h00; // Latched index after reset.
	localparam logic [7:0] WDC_IDLE_READ = 8'hff; // Answer to a read that nothing claims.

	// -------------------------------------------------------------------------
	// Timing.
	// -------------------------------------------------------------------------
	localparam int unsigned WDC_CLK_HZ           = 20_000_000; // Core clock rate.
	localparam int unsigned WDC_UNIT_SECONDS     = 1;          // Base counting unit in seconds.
	localparam int unsigned WDC_SECONDS_PER_MIN  = 60;         // Seconds in the long counting unit.
	localparam int unsigned WDC_CYC_PER_SECOND   = WDC_UNIT_SECONDS * WDC_CLK_HZ; // Cycles in one second.

endpackage : wdc_pkg

// >>> core/wdc_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Link between the register logic and the unit tick generator.
// -----------------------------------------------------------------------------
interface wdc_tick_if;
	logic restart;     // Restart the prescaler so the next unit is a full one.
	logic unitMinutes; // High counts minutes, low counts seconds.
	logic tick;        // One-cycle pulse at the end of each counting unit.

	// Register side drives the control and consumes the tick.
	modport ctrl (output restart, output unitMinutes, input tick);
	// Generator side consumes the control and drives the tick.
	modport gen (input restart, input unitMinutes, output tick);
endinterface : wdc_tick_if
`default_nettype wire

// >>> core/wdc_tick_gen.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Unit tick generator: one pulse per second or per minute.
// -----------------------------------------------------------------------------
module wdc_tick_gen import wdc_pkg::*; #(
	parameter int unsigned CYC_PER_UNIT = WDC_CYC_PER_SECOND
) (
	input  wire logic clk,
	input  wire logic nrst,
	wdc_tick_if.gen   link
);
	localparam int CW = $clog2(CYC_PER_UNIT);
	localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_UNIT - 1);
	localparam logic [5:0]    SEC_LAST = 6'(WDC_SECONDS_PER_MIN - 1);

	// -------------------------------------------------------------------------
	// Elaboration check.
	// -------------------------------------------------------------------------
	if (CYC_PER_UNIT < 2) begin : g_badCyc
		$error("CYC_PER_UNIT must be at least 2");
	end

	logic [CW-1:0] cycCnt;  // Cycles within the current second.
	logic [5:0]    secCnt;  // Seconds within the current minute.
	logic          secWrap; // Last cycle of a second.

	assign secWrap = (cycCnt == CYC_LAST);

	// Cycle prescaler; a restart makes the following unit a whole one.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cycCnt <= '0;
		end else if (link.restart || secWrap) begin
			cycCnt <= '0;
		end else begin
			cycCnt <= cycCnt + CW'(1);
		end
	end

	// Seconds counter, only of use in minute mode.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			secCnt <= '0;
		end else if (link.restart) begin
			secCnt <= '0;
		end else if (secWrap) begin
			secCnt <= (secCnt == SEC_LAST) ? 6'h00 : secCnt + 6'h01;
		end
	end

	// Tick pulse; suppressed on a restart so a fresh load never loses a unit.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			link.tick <= 1'b0;
		end else begin
			link.tick <= !link.restart && secWrap && (!link.unitMinutes || secCnt == SEC_LAST);
		end
	end

	// Ticks are never adjacent, as every unit spans at least two cycles.
	property p_tickSpaced;
		@(posedge clk) disable iff (!nrst) link.tick |=> !link.tick;
	endproperty
	a_tickSpaced: assert property (p_tickSpaced) else $error("Two ticks in a row");

endmodule : wdc_tick_gen
`default_nettype wire

// >>> core/wdc_top.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Watchdog behind an index/data configuration port pair.
// -----------------------------------------------------------------------------
module wdc_top import wdc_pkg::*; #(
	parameter int unsigned CYC_PER_UNIT = WDC_CYC_PER_SECOND
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [15:0] ioAddr,
	input  wire logic        ioWr,
	input  wire logic        ioRd,
	input  wire logic [7:0]  ioWrData,
	output var  logic [7:0]  ioRdData,
	output var  logic        ioRdValid,
	output var  logic        configActive,
	output var  logic        wdTimeout
);

	// -------------------------------------------------------------------------
	// Declarations.
	// -------------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_LOCKED = 3'b001, // Normal operation, watching for the unlock pair.
		ST_HALF   = 3'b010, // One unlock byte seen.
		ST_CONFIG = 3'b100  // Configuration mode.
	} wdc_state_e;

	wdc_state_e state;      // Unlock state.
	wdc_state_e next_state; // Unlock state for the next cycle.
	logic [7:0] regIndex;   // Latched register index.
	logic [7:0] ldnSel;     // Logical device select register.
	logic [7:0] unitCtl;    // Watchdog unit control register.
	logic [7:0] count;      // Remaining watchdog count.
	logic       idxHit;     // Access addresses the index port.
	logic       dataHit;    // Access addresses the data port.
	logic       idxWr;      // Write to the index port.
	logic       dataWr;     // Write to the data port.
	logic       cfg;        // Configuration mode is active.
	logic       wrLdn;      // Data write to the logical device select.
	logic       wrUnit;     // Data write to the unit control register.
	logic       wrCount;    // Data write to the timeout count register.

	wdc_tick_if tickIf ();

	// Decode of a watchdog bank register, shared by writes and reads.
	function automatic logic wdBankHit(input logic [7:0] idx, input logic [7:0] ldn,
			input logic [7:0] target);
		wdBankHit = (ldn == WDC_LDN_WATCHDOG) && (idx == target);
	endfunction : wdBankHit

	// -------------------------------------------------------------------------
	// Port decode.
	// -------------------------------------------------------------------------
	assign idxHit  = (ioAddr == WDC_INDEX_PORT);
	assign dataHit = (ioAddr == WDC_DATA_PORT);
	assign idxWr   = ioWr && idxHit;
	assign dataWr  = ioWr && dataHit;
	assign cfg     = (state == ST_CONFIG);
	// Register writes only act in configuration mode, so a locked device ignores them.
	assign wrLdn   = cfg && dataWr && (regIndex == WDC_IDX_LDN);
	assign wrUnit  = cfg && dataWr && wdBankHit(regIndex, ldnSel, WDC_IDX_UNIT);
	assign wrCount = cfg && dataWr && wdBankHit(regIndex, ldnSel, WDC_IDX_COUNT);

	// -------------------------------------------------------------------------
	// Unlock and lock sequencing.
	// -------------------------------------------------------------------------
	// Any access to either port other than a second unlock byte breaks the pair,
	// so the two unlock writes must truly follow one another.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_LOCKED: begin
				if (idxWr && ioWrData == WDC_UNLOCK_BYTE) begin
					next_state = ST_HALF;
				end
			end
			ST_HALF: begin
				if (idxWr && ioWrData == WDC_UNLOCK_BYTE) begin
					next_state = ST_CONFIG;
				end else if ((ioWr || ioRd) && (idxHit || dataHit)) begin
					next_state = ST_LOCKED;
				end
			end
			ST_CONFIG: begin
				if (idxWr && ioWrData == WDC_LOCK_BYTE) begin
					next_state = ST_LOCKED;
				end
			end
		endcase
	end

	// State register and its visible copy.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state        <= ST_LOCKED;
			configActive <= 1'b0;
		end else begin
			state        <= next_state;
			configActive <= (next_state == ST_CONFIG);
		end
	end

	// -------------------------------------------------------------------------
	// Configuration registers.
	// -------------------------------------------------------------------------
	// Index latch; the lock byte is a command and is not kept as an index.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			regIndex <= WDC_RST_INDEX;
		end else if (cfg && idxWr && ioWrData != WDC_LOCK_BYTE) begin
			regIndex <= ioWrData;
		end
	end

	// Logical device select steers which bank later indices reach.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ldnSel <= WDC_RST_LDN;
		end else if (wrLdn) begin
			ldnSel <= ioWrData;
		end
	end

	// Unit control; all bits are kept so a read-modify-write returns them.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			unitCtl <= WDC_RST_UNIT;
		end else if (wrUnit) begin
			unitCtl <= ioWrData;
		end
	end

	// -------------------------------------------------------------------------
	// Watchdog countdown.
	// -------------------------------------------------------------------------
	assign tickIf.unitMinutes = unitCtl[WDC_UNIT_BIT];
	// A new count or a new unit restarts the prescaler, giving full units.
	assign tickIf.restart     = wrCount || wrUnit;

	wdc_tick_gen #(
		.CYC_PER_UNIT (CYC_PER_UNIT)
	) u_tick (
		.clk  (clk),
		.nrst (nrst),
		.link (tickIf)
	);

	// A load wins over a tick; a zero count never moves, which stops the timer.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count <= WDC_RST_COUNT;
		end else if (wrCount) begin
			count <= ioWrData;
		end else if (tickIf.tick && count != 8'h00) begin
			count <= count - 8'h01;
		end
	end

	// Timeout holds until software loads a new count, so the reset is not missed.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wdTimeout <= 1'b0;
		end else if (wrCount) begin
			wdTimeout <= 1'b0;
		end else if (tickIf.tick && count == 8'h01) begin
			wdTimeout <= 1'b1;
		end
	end

	// -------------------------------------------------------------------------
	// Read path.
	// -------------------------------------------------------------------------
	// Reads answer one cycle later; a locked device returns the idle value.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ioRdData  <= WDC_IDLE_READ;
			ioRdValid <= 1'b0;
		end else begin
			ioRdValid <= ioRd && (idxHit || dataHit);
			if (!(ioRd && cfg)) begin
				ioRdData <= WDC_IDLE_READ;
			end else if (idxHit) begin
				ioRdData <= regIndex;
			end else if (regIndex == WDC_IDX_LDN) begin
				ioRdData <= ldnSel;
			end else if (wdBankHit(regIndex, ldnSel, WDC_IDX_UNIT)) begin
				ioRdData <= unitCtl;
			end else if (wdBankHit(regIndex, ldnSel, WDC_IDX_COUNT)) begin
				ioRdData <= count;
			end else begin
				ioRdData <= WDC_IDLE_READ;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Assertions.
	// -------------------------------------------------------------------------
	property p_idxLatch;
		@(posedge clk) disable iff (!nrst)
		cfg && idxWr && ioWrData != WDC_LOCK_BYTE |=> regIndex == $past(ioWrData);
	endproperty
	a_idxLatch: assert property (p_idxLatch) else $error("Index not latched");

	property p_unlock;
		@(posedge clk) disable iff (!nrst)
		(state == ST_LOCKED && idxWr && ioWrData == WDC_UNLOCK_BYTE)
		##1 (idxWr && ioWrData == WDC_UNLOCK_BYTE) |=> configActive;
	endproperty
	a_unlock: assert property (p_unlock) else $error("Unlock pair did not enter configuration");

	property p_lock;
		@(posedge clk) disable iff (!nrst)
		cfg && idxWr && ioWrData == WDC_LOCK_BYTE |=> !configActive [*2];
	endproperty
	a_lock: assert property (p_lock) else $error("Lock byte did not leave configuration");

	property p_ldn;
		@(posedge clk) disable iff (!nrst)
		cfg && dataWr && regIndex == WDC_IDX_LDN |=> ldnSel == $past(ioWrData);
	endproperty
	a_ldn: assert property (p_ldn) else $error("Device select not written");

	property p_bank;
		@(posedge clk) disable iff (!nrst)
		dataWr && ldnSel != WDC_LDN_WATCHDOG && !tickIf.tick |=> count == $past(count);
	endproperty
	a_bank: assert property (p_bank) else $error("Count written outside the watchdog bank");

	property p_unitRead;
		@(posedge clk) disable iff (!nrst)
		cfg && ioRd && dataHit && wdBankHit(regIndex, ldnSel, WDC_IDX_UNIT)
		|=> ioRdValid && ioRdData == $past(unitCtl);
	endproperty
	a_unitRead: assert property (p_unitRead) else $error("Unit register read wrong");

	property p_load;
		@(posedge clk) disable iff (!nrst)
		wrCount |=> count == $past(ioWrData) && !wdTimeout;
	endproperty
	a_load: assert property (p_load) else $error("Count not loaded");

	property p_decrement;
		@(posedge clk) disable iff (!nrst)
		tickIf.tick && count > 8'h01 && !wrCount |=> count == $past(count) - 8'h01;
	endproperty
	a_decrement: assert property (p_decrement) else $error("Count did not step");

	property p_expire;
		@(posedge clk) disable iff (!nrst)
		tickIf.tick && count == 8'h01 && !wrCount |=> wdTimeout && count == 8'h00;
	endproperty
	a_expire: assert property (p_expire) else $error("Timeout not raised");

	property p_ignore;
		@(posedge clk) disable iff (!nrst)
		state == ST_HALF && (ioWr || ioRd) && (idxHit || dataHit)
		&& !(idxWr && ioWrData == WDC_UNLOCK_BYTE) |=> !configActive && state == ST_LOCKED;
	endproperty
	a_ignore: assert property (p_ignore) else $error("Broken unlock pair accepted");

endmodule : wdc_top
`default_nettype wire

// >>> tb/wdc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Host model issuing byte-wide I/O cycles to the index and data ports.
// -----------------------------------------------------------------------------
module wdc_host_model import wdc_pkg::*; (
	input  wire logic        clk,
	output var  logic [15:0] ioAddr,
	output var  logic        ioWr,
	output var  logic        ioRd,
	output var  logic [7:0]  ioWrData,
	input  wire logic [7:0]  ioRdData,
	input  wire logic        ioRdValid
);
	// The bus is idle at time zero and points at neither port.
	initial begin
		ioAddr   = 16'h0000;
		ioWr     = 1'b0;
		ioRd     = 1'b0;
		ioWrData = 8'h00;
	end

	// One write cycle; released lines show inverted values so stale data never passes for a match.
	task automatic portWrite(input logic [15:0] addr, input logic [7:0] data);
		@(posedge clk);
		ioWr     <= 1'b1;
		ioAddr   <= addr;
		ioWrData <= data;
		@(posedge clk);
		ioWr     <= 1'b0;
		ioAddr   <= ~addr;
		ioWrData <= ~data;
	endtask : portWrite

	// One read cycle; the answer is taken in the cycle after the strobe is sampled.
	task automatic portRead(input logic [15:0] addr, output logic [7:0] data, output logic valid);
		@(posedge clk);
		ioRd   <= 1'b1;
		ioAddr <= addr;
		@(posedge clk);
		ioRd   <= 1'b0;
		ioAddr <= ~addr;
		@(negedge clk);
		data  = ioRdData;
		valid = ioRdValid;
	endtask : portRead

	// The unlock pair, back to back, before any configuration access.
	task automatic unlock;
		portWrite(WDC_INDEX_PORT, WDC_UNLOCK_BYTE);
		portWrite(WDC_INDEX_PORT, WDC_UNLOCK_BYTE);
	endtask : unlock

	// A single lock byte when configuring is finished.
	task automatic lock;
		portWrite(WDC_INDEX_PORT, WDC_LOCK_BYTE);
	endtask : lock

	// The index always goes out before the data access that it is meant for.
	task automatic regWrite(input logic [7:0] idx, input logic [7:0] data);
		portWrite(WDC_INDEX_PORT, {8'h00, idx}[7:0]);
		portWrite(WDC_DATA_PORT, data);
	endtask : regWrite

	// Index first, then a data port read.
	task automatic regRead(input logic [7:0] idx, output logic [7:0] data, output logic valid);
		portWrite(WDC_INDEX_PORT, idx);
		portRead(WDC_DATA_PORT, data, valid);
	endtask : regRead
endmodule : wdc_host_model
`default_nettype wire

// >>> tb/wdc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
// -----------------------------------------------------------------------------
// Self-checking bench for the watchdog configuration port.
// -----------------------------------------------------------------------------
module wdc_top_tb import wdc_pkg::*; ;
	localparam int CYC = 4; // Short counting unit keeps the minute case brief.

	logic        clk = 1'b0;   // Core clock, 50 ns period.
	logic        nrst = 1'b0;  // Active low reset.
	logic [15:0] ioAddr;       // Port address from the host.
	logic        ioWr;         // Write strobe.
	logic        ioRd;         // Read strobe.
	logic [7:0]  ioWrData;     // Write byte.
	logic [7:0]  ioRdData;     // Read byte.
	logic        ioRdValid;    // Read answer pulse.
	logic        configActive; // Configuration mode flag.
	logic        wdTimeout;    // Expiry level.
	int          errors = 0;     // Mismatches seen.
	int          checkCount = 0; // Comparisons made.
	logic [7:0]  rdData;       // Scratch read byte.
	logic        rdValid;      // Scratch read pulse.

	always #25 clk = ~clk;

	wdc_top #(.CYC_PER_UNIT(CYC)) dut_u (
		.clk(clk), .nrst(nrst), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .ioRdValid(ioRdValid), .configActive(configActive), .wdTimeout(wdTimeout)
	);

	wdc_host_model host_u (
		.clk(clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData),
		.ioRdData(ioRdData), .ioRdValid(ioRdValid)
	);

	// -------------------------------------------------------------------------
	// Shared helpers.
	// -------------------------------------------------------------------------
	// Case inequality so that an unknown never passes for a match.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checkCount++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Register read through the port pair, with the answer pulse checked too.
	task automatic rdChk(input string what, input logic [7:0] idx, input logic [7:0] exp);
		host_u.regRead(idx, rdData, rdValid);
		chk(what, exp, rdData);
		chk("ioRdValid", 8'h01, {7'h00, rdValid});
	endtask : rdChk

	// Expiry must come exactly t edges after the load edge, not one earlier.
	task automatic waitExpiry(input int t);
		repeat (t - 1) @(posedge clk);
		@(negedge clk);
		chk("wdTimeout early", 8'h00, {7'h00, wdTimeout});
		@(posedge clk);
		@(negedge clk);
		chk("wdTimeout due", 8'h01, {7'h00, wdTimeout});
	endtask : waitExpiry

	// -------------------------------------------------------------------------
	// Scenarios.
	// -------------------------------------------------------------------------
	// Locked device: writes are dropped and reads answer the idle byte.
	task automatic tLocked;
		@(negedge clk);
		chk("configActive", 8'h00, {7'h00, configActive});
		chk("wdTimeout", 8'h00, {7'h00, wdTimeout});
		host_u.portWrite(WDC_INDEX_PORT, {8'h00, WDC_IDX_LDN});
		host_u.portWrite(WDC_DATA_PORT, WDC_LDN_WATCHDOG);
		host_u.portRead(WDC_DATA_PORT, rdData, rdValid);
		chk("locked read", WDC_IDLE_READ, rdData);
		chk("locked ioRdValid", 8'h01, {7'h00, rdValid});
	endtask : tLocked

	// A stray byte between unlock bytes restarts detection; one lock byte leaves.
	task automatic tUnlock;
		host_u.portWrite(WDC_INDEX_PORT, {8'h00, WDC_UNLOCK_BYTE});
		host_u.portWrite(WDC_INDEX_PORT, 16'h0055);
		host_u.portWrite(WDC_INDEX_PORT, {8'h00, WDC_UNLOCK_BYTE});
		@(negedge clk);
		chk("configActive stray", 8'h00, {7'h00, configActive});
		host_u.portWrite(WDC_INDEX_PORT, {8'h00, WDC_UNLOCK_BYTE});
		@(negedge clk);
		chk("configActive pair", 8'h01, {7'h00, configActive});
		host_u.lock();
		@(negedge clk);
		chk("configActive lock", 8'h00, {7'h00, configActive});
	endtask : tUnlock

	// Bank selection, reset values, read back and unmapped places.
	task automatic tBanks;
		host_u.unlock();
		rdChk("device select", WDC_IDX_LDN, WDC_RST_LDN);
		host_u.regWrite(WDC_IDX_LDN, 8'h05);
		host_u.regWrite(WDC_IDX_UNIT, 8'h08);
		rdChk("unit other bank", WDC_IDX_UNIT, WDC_IDLE_READ);
		host_u.regWrite(WDC_IDX_LDN, WDC_LDN_WATCHDOG);
		rdChk("device select", WDC_IDX_LDN, WDC_LDN_WATCHDOG);
		rdChk("unit reset", WDC_IDX_UNIT, WDC_RST_UNIT);
		rdChk("count reset", WDC_IDX_COUNT, WDC_RST_COUNT);
		host_u.regWrite(WDC_IDX_UNIT, 8'h08);
		rdChk("unit", WDC_IDX_UNIT, 8'h08);
		host_u.portRead(WDC_INDEX_PORT, rdData, rdValid);
		chk("latched index", WDC_IDX_UNIT, rdData);
		rdChk("unmapped", 8'h30, WDC_IDLE_READ);
	endtask : tBanks

	// Second units: expiry, stop by zero, and a kick that restarts the unit.
	task automatic tSeconds;
		host_u.regWrite(WDC_IDX_UNIT, 8'h00);
		host_u.regWrite(WDC_IDX_COUNT, 8'h02);
		waitExpiry(CYC * 2 + 1);
		rdChk("count left", WDC_IDX_COUNT, 8'h00);
		host_u.regWrite(WDC_IDX_COUNT, 8'h00);
		@(negedge clk);
		chk("wdTimeout cleared", 8'h00, {7'h00, wdTimeout});
		repeat (40) @(posedge clk);
		@(negedge clk);
		chk("wdTimeout stopped", 8'h00, {7'h00, wdTimeout});
		host_u.regWrite(WDC_IDX_COUNT, 8'h01);
		host_u.regWrite(WDC_IDX_COUNT, 8'h01);
		waitExpiry(CYC + 1);
	endtask : tSeconds

	// Minute units, then a locked count write that must not clear the expiry.
	task automatic tMinutes;
		host_u.regWrite(WDC_IDX_UNIT, 8'h08);
		host_u.regWrite(WDC_IDX_COUNT, 8'h01);
		waitExpiry(WDC_SECONDS_PER_MIN * CYC + 1);
		host_u.lock();
		host_u.regWrite(WDC_IDX_COUNT, 8'h00);
		@(negedge clk);
		chk("wdTimeout locked", 8'h01, {7'h00, wdTimeout});
	endtask : tMinutes

	// -------------------------------------------------------------------------
	// Verdict and run control.
	// -------------------------------------------------------------------------
	task automatic report_and_stop;
		if (errors == 0 && checkCount > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop

	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		tLocked();
		tUnlock();
		tBanks();
		tSeconds();
		tMinutes();
		report_and_stop();
	end

	// The tests need well under a thousand cycles; this cuts a hang short.
	initial begin
		#(5000 * 50);
		errors++;
		report_and_stop();
	end
endmodule : wdc_top_tb
`default_nettype wire
